// *** core/p3p_params.svh ***
// constants for the port pin mode and alternate function block
`ifndef P3P_PARAMS_SVH
`define P3P_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define P3P_ADDR_W        3
`define P3P_OFS_LATCH     3'h0
`define P3P_OFS_MODE_LO   3'h1
`define P3P_OFS_MODE_HI   3'h2
`define P3P_OFS_PIN_STATE 3'h3
`define P3P_OFS_IRQ_STAT  3'h4
`define P3P_OFS_IRQ_EN    3'h5
`define P3P_OFS_IRQ_CLR   3'h6

// ****************************************
// reset values
// ****************************************
`define P3P_LATCH_RST     8'hFF
`define P3P_MODE_RST      8'h00
`define P3P_IRQ_RST       4'h0

// ****************************************
// interrupt status bit positions
// ****************************************
`define P3P_IRQ_W         4
`define P3P_IRQ_CCRST     0
`define P3P_IRQ_EXT0      1
`define P3P_IRQ_EXT1      2
`define P3P_IRQ_WDT       3

// ****************************************
// timing
// ****************************************
`define P3P_CLK_MHZ       200
`define P3P_RST_PULSE_NS  100
`define P3P_CNT_W         16

`endif

// *** core/p3p_pkg.sv ***
// types shared by the port pin block
package p3p_pkg;

	// ****************************************
	// pin output modes, order follows {low,high} select bits
	// ****************************************
	typedef enum logic [1:0] {
		P3P_QUASI,
		P3P_PUSH,
		P3P_HIZ,
		P3P_ODRAIN
	} p3p_mode_e;

	// ****************************************
	// reset pin driver states
	// ****************************************
	typedef enum logic [0:0] {
		P3P_RST_IDLE,
		P3P_RST_PULSE
	} p3p_rst_e;

endpackage

// *** core/p3p_sync.sv ***
// three-stage input synchroniser with agreement filter
module p3p_sync
	import p3p_pkg::*;
#(
	parameter int               WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ****************************************
	// stages
	// ****************************************
	logic [WIDTH-1:0] s1_r;    // first stage, read by s2 only
	logic [WIDTH-1:0] s2_r;    // second stage
	logic [WIDTH-1:0] s3_r;    // third stage
	wire  [WIDTH-1:0] agree_w; // second and third stage match

	assign agree_w = s2_r ~^ s3_r;

	// shift chain, output follows once two stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r     <= RST_VAL;
			s2_r     <= RST_VAL;
			s3_r     <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			s1_r     <= async_in;
			s2_r     <= s1_r;
			s3_r     <= s2_r;
			sync_out <= (agree_w & s3_r) | (~agree_w & sync_out);
		end
	end

endmodule

// *** core/p3p_port.sv ***
// eight-bit port with per-pin output modes, alternate functions and reset pin
//
// Function
// (RULE1) mode per pin from two select registers
// (RULE2) select bits 00 give quasi-bidirectional default
// (RULE3) 01 push-pull, 10 high-z, 11 open drain
// (RULE4) reset drives all pins resistively high asynchronously
// (RULE5) reset pin resets device, pulses on watchdog
// (RULE6) pin 0 serial receive, capcomp event
// (RULE7) pin 1 serial transmit, capcomp reset rising
// (RULE8) pins 2,3 irqs; pins 2-5 compare outputs
// (RULE9) pins 4,5 timer zero/one count inputs
// (RULE10) pins 6,7 external write/read strobes
// (RULE11) alternate output ANDed with latch, mode applies
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`include "p3p_params.svh"
module p3p_port
	import p3p_pkg::*;
#(
	parameter int   CLK_MHZ        = `P3P_CLK_MHZ,
	parameter int   RST_PULSE_NS   = `P3P_RST_PULSE_NS,
	parameter logic RST_ACTIVE_LVL = 1'b0 // pin level that means reset
) (
	input  wire logic                  CLOCK,
	input  wire logic                  RESET,
	input  wire logic [`P3P_ADDR_W-1:0] ADDR,
	input  wire logic [7:0]            WDATA,
	input  wire logic                  WR_STB,
	input  wire logic                  RD_STB,
	output logic      [7:0]            RDATA,
	input  wire logic [7:0]            PIN_IN,
	output logic      [7:0]            PIN_OUT,
	output logic      [7:0]            PIN_OE,
	output logic      [7:0]            PIN_PULLUP,
	input  wire logic                  RST_PIN_IN,
	output logic                       RST_PIN_OUT,
	output logic                       RST_PIN_OE,
	output logic                       DEVICE_RESET,
	input  wire logic                  WATCHDOG_TIMER_OVF,
	input  wire logic                  UART_TXD,
	input  wire logic                  UART_TXD_EN,
	input  wire logic [3:0]            COMPARE_SETRESET_OUT,
	input  wire logic [3:0]            COMPARE_SETRESET_EN,
	input  wire logic                  XDATA_ACCESS,
	input  wire logic                  XDATA_WR_N,
	input  wire logic                  XDATA_RD_N,
	output logic                       UART_RXD,
	output logic                       CAPCOMP_TIMER_EVENT_IN,
	output logic                       CAPCOMP_TIMER_RESET_IN,
	output logic                       EXT_IRQ_ZERO,
	output logic                       EXT_IRQ_ONE,
	output logic                       TIMER_ZERO_COUNT_IN,
	output logic                       TIMER_ONE_COUNT_IN,
	output logic                       IRQ
);

	// ****************************************
	// derived timing
	// ****************************************
	localparam int RST_PULSE_RAW = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_PULSE_CYC = (RST_PULSE_RAW < 1) ? 1 : RST_PULSE_RAW;
	localparam logic [`P3P_CNT_W-1:0] PULSE_LOAD = `P3P_CNT_W'(RST_PULSE_CYC - 1);

	// ****************************************
	// functions
	// ****************************************
	// strobe hit on one register offset
	function automatic logic hit(input logic [`P3P_ADDR_W-1:0] a,
	                             input logic [`P3P_ADDR_W-1:0] o,
	                             input logic                   s);
		hit = s && (a == o);
	endfunction

	// pin drive {oe, out, pullup} from mode and data
	function automatic logic [2:0] drive(input p3p_mode_e m, input logic d);
		case (m)
			P3P_QUASI:  drive = {~d, 1'b0, d};  // low strong, high weak
			P3P_PUSH:   drive = {1'b1, d, 1'b0}; // both levels strong
			P3P_HIZ:    drive = 3'h0;            // input only
			P3P_ODRAIN: drive = {~d, 1'b0, 1'b0}; // low only, no pullup
			default:    drive = 3'h0;
		endcase
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [7:0]            latch_r;    // port output latch
	logic [7:0]            mode_lo_r;  // low mode select bits
	logic [7:0]            mode_hi_r;  // high mode select bits
	logic [`P3P_IRQ_W-1:0] irq_en_r;   // interrupt enables
	logic [`P3P_IRQ_W-1:0] irq_stat_r; // sticky event bits
	logic [`P3P_IRQ_W-1:0] irq_stat_nxt;
	logic [7:0]            oe_r;       // registered pin enables
	logic [7:0]            out_r;      // registered pin data
	logic [7:0]            pu_r;       // registered pullups
	logic [8:0]            pin_q;      // filtered pins, bit 8 reset pin
	logic [8:0]            prev_q;     // filtered pins one cycle back
	p3p_rst_e              rst_st_r;   // reset pin driver state
	p3p_rst_e              rst_st_nxt;
	logic [`P3P_CNT_W-1:0] cnt_r;      // pulse length counter
	logic [`P3P_CNT_W-1:0] cnt_nxt;

	// ****************************************
	// input synchroniser
	// ****************************************
	p3p_sync #(
		.WIDTH   (9),
		.RST_VAL ({~RST_ACTIVE_LVL, 8'hFF})
	) u_sync (
		.clk      (CLOCK),
		.rst      (RESET),
		.async_in ({RST_PIN_IN, PIN_IN}),
		.sync_out (pin_q)
	);

	// ****************************************
	// register decode
	// ****************************************
	wire wr_latch_w   = hit(ADDR, `P3P_OFS_LATCH, WR_STB);
	wire wr_mode_lo_w = hit(ADDR, `P3P_OFS_MODE_LO, WR_STB);
	wire wr_mode_hi_w = hit(ADDR, `P3P_OFS_MODE_HI, WR_STB);
	wire wr_irq_en_w  = hit(ADDR, `P3P_OFS_IRQ_EN, WR_STB);
	wire wr_irq_clr_w = hit(ADDR, `P3P_OFS_IRQ_CLR, WR_STB);
	wire [`P3P_IRQ_W-1:0] clr_mask_w = wr_irq_clr_w ? WDATA[`P3P_IRQ_W-1:0] : '0;

	// read selection, unmapped and write-only offsets read zero
	wire [7:0] rd_val_w =
		(ADDR == `P3P_OFS_LATCH)     ? latch_r :
		(ADDR == `P3P_OFS_MODE_LO)   ? mode_lo_r :
		(ADDR == `P3P_OFS_MODE_HI)   ? mode_hi_r :
		(ADDR == `P3P_OFS_PIN_STATE) ? pin_q[7:0] :
		(ADDR == `P3P_OFS_IRQ_STAT)  ? {4'h0, irq_stat_r} :
		(ADDR == `P3P_OFS_IRQ_EN)    ? {4'h0, irq_en_r} : 8'h00;

	// ****************************************
	// alternate outputs and pin drive
	// ****************************************
	// pin 0 has no alternate output
	wire [7:0] alt_en_w  = {XDATA_ACCESS, XDATA_ACCESS, COMPARE_SETRESET_EN,
	                        UART_TXD_EN, 1'b0}; // RULE7 RULE8 RULE10
	wire [7:0] alt_val_w = {XDATA_RD_N, XDATA_WR_N, COMPARE_SETRESET_OUT,
	                        UART_TXD, 1'b1}; // RULE7 RULE8 RULE10
	// inactive alternate leaves the latch alone
	wire [7:0] eff_w     = latch_r & (alt_val_w | ~alt_en_w); // RULE11
	wire [7:0] push_w    = ~mode_lo_r & mode_hi_r;
	wire [7:0] hiz_w     = mode_lo_r & ~mode_hi_r;
	wire [7:0] od_w      = mode_lo_r & mode_hi_r;
	wire [2:0] drv_w [8];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			// per-pin mode from the matching bit of both selects
			assign drv_w[gi] = drive(p3p_mode_e'({mode_lo_r[gi], mode_hi_r[gi]}),
			                         eff_w[gi]); // RULE1 RULE2 RULE3
		end
	endgenerate

	wire [7:0] oe_nxt_w;
	wire [7:0] out_nxt_w;
	wire [7:0] pu_nxt_w;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_split
			assign oe_nxt_w[gi]  = drv_w[gi][2];
			assign out_nxt_w[gi] = drv_w[gi][1];
			assign pu_nxt_w[gi]  = drv_w[gi][0];
		end
	endgenerate

	// ****************************************
	// events
	// ****************************************
	wire [`P3P_IRQ_W-1:0] evt_w;
	assign evt_w[`P3P_IRQ_CCRST] = pin_q[1] & ~prev_q[1]; // RULE7
	assign evt_w[`P3P_IRQ_EXT0]  = ~pin_q[2] & prev_q[2];
	assign evt_w[`P3P_IRQ_EXT1]  = ~pin_q[3] & prev_q[3];
	assign evt_w[`P3P_IRQ_WDT]   = WATCHDOG_TIMER_OVF;

	// set beats a clear in the same cycle
	assign irq_stat_nxt = (irq_stat_r & ~clr_mask_w) | evt_w;

	// ****************************************
	// reset pin pulse control
	// ****************************************
	always_comb begin
		rst_st_nxt = rst_st_r;
		cnt_nxt    = cnt_r;
		case (rst_st_r)
			P3P_RST_IDLE: begin
				// watchdog overflow starts a pulse
				if (WATCHDOG_TIMER_OVF) begin
					rst_st_nxt = P3P_RST_PULSE; // RULE5
					cnt_nxt    = PULSE_LOAD;
				end
			end
			P3P_RST_PULSE: begin
				// count out the pulse length
				if (cnt_r == '0) begin
					rst_st_nxt = P3P_RST_IDLE;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			default: begin
				rst_st_nxt = P3P_RST_IDLE;
				cnt_nxt    = '0;
			end
		endcase
	end

	// ****************************************
	// registers
	// ****************************************
	// software registers
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			latch_r    <= `P3P_LATCH_RST;
			mode_lo_r  <= `P3P_MODE_RST; // RULE2
			mode_hi_r  <= `P3P_MODE_RST; // RULE2
			irq_en_r   <= `P3P_IRQ_RST;
			irq_stat_r <= `P3P_IRQ_RST;
			RDATA      <= 8'h00;
		end else begin
			if (wr_latch_w)   latch_r   <= WDATA;
			if (wr_mode_lo_w) mode_lo_r <= WDATA; // RULE1
			if (wr_mode_hi_w) mode_hi_r <= WDATA; // RULE1
			if (wr_irq_en_w)  irq_en_r  <= WDATA[`P3P_IRQ_W-1:0];
			irq_stat_r <= irq_stat_nxt;
			RDATA      <= RD_STB ? rd_val_w : 8'h00;
		end
	end

	// pin drivers
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			oe_r  <= 8'h00;
			out_r <= 8'hFF;
			pu_r  <= 8'hFF;
		end else begin
			oe_r  <= oe_nxt_w; // RULE3
			out_r <= out_nxt_w; // RULE3
			pu_r  <= pu_nxt_w; // RULE2
		end
	end

	// reset forces weak high without waiting for an edge
	assign PIN_OE     = oe_r & {8{~RESET}}; // RULE4
	assign PIN_PULLUP = pu_r | {8{RESET}}; // RULE4
	assign PIN_OUT    = out_r;

	// alternate inputs, reset pin and interrupt output
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			prev_q                 <= 9'h1FF;
			UART_RXD               <= 1'b1;
			CAPCOMP_TIMER_EVENT_IN <= 1'b1;
			CAPCOMP_TIMER_RESET_IN <= 1'b0;
			EXT_IRQ_ZERO           <= 1'b1;
			EXT_IRQ_ONE            <= 1'b1;
			TIMER_ZERO_COUNT_IN    <= 1'b1;
			TIMER_ONE_COUNT_IN     <= 1'b1;
			rst_st_r               <= P3P_RST_IDLE;
			cnt_r                  <= '0;
			RST_PIN_OE             <= 1'b0;
			RST_PIN_OUT            <= RST_ACTIVE_LVL;
			DEVICE_RESET           <= 1'b0;
			IRQ                    <= 1'b0;
		end else begin
			prev_q                 <= pin_q;
			UART_RXD               <= pin_q[0]; // RULE6
			CAPCOMP_TIMER_EVENT_IN <= pin_q[0]; // RULE6
			CAPCOMP_TIMER_RESET_IN <= evt_w[`P3P_IRQ_CCRST]; // RULE7
			EXT_IRQ_ZERO           <= pin_q[2]; // RULE8
			EXT_IRQ_ONE            <= pin_q[3]; // RULE8
			TIMER_ZERO_COUNT_IN    <= pin_q[4]; // RULE9
			TIMER_ONE_COUNT_IN     <= pin_q[5]; // RULE9
			rst_st_r               <= rst_st_nxt;
			cnt_r                  <= cnt_nxt;
			RST_PIN_OE             <= (rst_st_nxt == P3P_RST_PULSE); // RULE5
			RST_PIN_OUT            <= RST_ACTIVE_LVL;
			DEVICE_RESET           <= (pin_q[8] == RST_ACTIVE_LVL); // RULE5
			IRQ                    <= |(irq_stat_nxt & irq_en_r);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	localparam int PULSE_A = RST_PULSE_CYC;

	sequence s_pulse_on;
		RST_PIN_OE && (RST_PIN_OUT == RST_ACTIVE_LVL);
	endsequence

	sequence s_pulse_off;
		!RST_PIN_OE;
	endsequence

	push_pull_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE3
		1 |=> ((PIN_OE & $past(push_w)) == $past(push_w)) &&
		      ((PIN_OUT & $past(push_w)) == ($past(eff_w) & $past(push_w))))
		else $error("push-pull pin not driven with its data");

	high_imp_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE3
		1 |=> ((PIN_OE | PIN_PULLUP) & $past(hiz_w)) == 8'h00)
		else $error("high impedance pin driven or pulled");

	open_drain_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE3
		1 |=> ((PIN_OE & $past(od_w)) == (~$past(eff_w) & $past(od_w))) &&
		      ((PIN_PULLUP & $past(od_w)) == 8'h00))
		else $error("open drain pin drive wrong");

	quasi_mode_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE2
		(mode_lo_r == 8'h00 && mode_hi_r == 8'h00) |=>
		(PIN_PULLUP == $past(eff_w)) && (PIN_OE == ~$past(eff_w)))
		else $error("quasi-bidirectional drive wrong");

	reset_high_a: assert property (@(posedge CLOCK) // RULE4
		RESET |-> (PIN_OE == 8'h00) && (PIN_PULLUP == 8'hFF))
		else $error("pins not weak high in reset");

	wdt_pulse_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE5
		(WATCHDOG_TIMER_OVF && rst_st_r == P3P_RST_IDLE) |=>
		s_pulse_on ##[PULSE_A:PULSE_A] s_pulse_off)
		else $error("reset pin pulse length wrong");

	cc_rise_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE7
		(pin_q[1] && !prev_q[1]) |=> CAPCOMP_TIMER_RESET_IN ##1 !CAPCOMP_TIMER_RESET_IN)
		else $error("capcomp reset not a one-cycle rise pulse");

	irq_in_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE8
		1 |=> (EXT_IRQ_ZERO == $past(pin_q[2])) && (EXT_IRQ_ONE == $past(pin_q[3])))
		else $error("external interrupt inputs not following pins");

	strobe_alt_a: assert property (@(posedge CLOCK) disable iff (RESET) // RULE10
		(XDATA_ACCESS && push_w[6] && latch_r[6]) |=> PIN_OUT[6] == $past(XDATA_WR_N))
		else $error("write strobe not on pin 6");

	set_wins_a: assert property (@(posedge CLOCK) disable iff (RESET)
		(evt_w[`P3P_IRQ_WDT] && clr_mask_w[`P3P_IRQ_WDT]) |=> irq_stat_r[`P3P_IRQ_WDT])
		else $error("event lost under clear");

	read_data_a: assert property (@(posedge CLOCK) disable iff (RESET)
		RD_STB |=> RDATA == $past(rd_val_w) ##1 ($past(RD_STB) || RDATA == 8'h00))
		else $error("read data timing wrong");

endmodule

// *** testbench/p3p_board.sv ***
// board model: pin wires, pull-ups and external drivers around the port
module p3p_board (
	input  wire logic       clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_lvl,
	input  wire logic       rst_out,
	input  wire logic       rst_oe,
	input  wire logic       rst_btn_n,
	output logic            rst_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] last_r; // last wire level, used while a pin floats
	// strong drive wins, then board driver, then weak pull-up, else drift
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_lvl[i] = pin_out[i];
			else if (ext_en[i])
				pin_lvl[i] = ext_val[i];
			else if (pin_pullup[i])
				pin_lvl[i] = 1'b1;
			else
				pin_lvl[i] = ~last_r[i];
		end
	end
	// floating pins show a level that changes every cycle
	always_ff @(posedge clk) last_r <= pin_lvl;
	// reset line has a board pull-up, button pulls it low
	assign rst_lvl = rst_oe ? rst_out : rst_btn_n;
endmodule

// *** testbench/p3p_port_tb.sv ***
// self-checking bench for the port pin block
`include "p3p_params.svh"
module p3p_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import p3p_pkg::*;
	localparam int PULSE_CYC = 100 * 200 / 1000; // reset pin pulse in cycles
	localparam logic [2:0] LAT = `P3P_OFS_LATCH;
	localparam logic [2:0] MLO = `P3P_OFS_MODE_LO;
	localparam logic [2:0] MHI = `P3P_OFS_MODE_HI;
	localparam logic [2:0] PST = `P3P_OFS_PIN_STATE;
	localparam logic [2:0] IST = `P3P_OFS_IRQ_STAT;
	localparam logic [2:0] IEN = `P3P_OFS_IRQ_EN;
	localparam logic [2:0] ICL = `P3P_OFS_IRQ_CLR;
	// one row: mode low, mode high, latch, then expected oe, out, pull-up
	typedef struct {logic [7:0] lo, hi, d, oe, out, pu;} p3p_row_s;
	p3p_row_s rows [7] = '{'{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'hFF},
		'{8'h00, 8'h00, 8'h5A, 8'hA5, 8'h00, 8'h5A}, '{8'h00, 8'hFF, 8'h5A, 8'hFF, 8'h5A, 8'h00},
		'{8'hFF, 8'h00, 8'h5A, 8'h00, 8'h00, 8'h00}, '{8'hFF, 8'hFF, 8'h5A, 8'hA5, 8'h00, 8'h00},
		'{8'h0F, 8'h33, 8'hF6, 8'h31, 8'h30, 8'hC0}, '{8'hF0, 8'hCC, 8'h39, 8'hCE, 8'h08, 8'h01}};
	logic       clock = 1'b0, reset = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata, pin_lvl, pin_out, pin_oe, pin_pu, q;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
	logic       rst_out, rst_oe, rst_lvl, dev_rst, rst_btn_n = 1'b1, wdt_ovf = 1'b0;
	logic       txd = 1'b1, txd_en = 1'b0, xacc = 1'b0, xwr_n = 1'b1, xrd_n = 1'b1;
	logic [3:0] cmp = 4'h0, cmp_en = 4'h0;
	logic       rxd, cc_ev, cc_rst, irq0, irq1, cnt0, cnt1, irq, seen;
	int         miscompares = 0, total_checks = 0, n;
	p3p_port #(.CLK_MHZ(200), .RST_PULSE_NS(100), .RST_ACTIVE_LVL(1'b0)) u_p3p_port (
		.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb),
		.RD_STB(rd_stb), .RDATA(rdata), .PIN_IN(pin_lvl), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.PIN_PULLUP(pin_pu), .RST_PIN_IN(rst_lvl), .RST_PIN_OUT(rst_out), .RST_PIN_OE(rst_oe),
		.DEVICE_RESET(dev_rst), .WATCHDOG_TIMER_OVF(wdt_ovf), .UART_TXD(txd),
		.UART_TXD_EN(txd_en), .COMPARE_SETRESET_OUT(cmp), .COMPARE_SETRESET_EN(cmp_en),
		.XDATA_ACCESS(xacc), .XDATA_WR_N(xwr_n), .XDATA_RD_N(xrd_n), .UART_RXD(rxd),
		.CAPCOMP_TIMER_EVENT_IN(cc_ev), .CAPCOMP_TIMER_RESET_IN(cc_rst), .EXT_IRQ_ZERO(irq0),
		.EXT_IRQ_ONE(irq1), .TIMER_ZERO_COUNT_IN(cnt0), .TIMER_ONE_COUNT_IN(cnt1), .IRQ(irq));
	p3p_board u_p3p_board (.clk(clock), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl),
		.rst_out(rst_out), .rst_oe(rst_oe), .rst_btn_n(rst_btn_n), .rst_lvl(rst_lvl));
	// 200 MHz clock
	initial begin
		forever #2.5 clock = ~clock;
	end
	// compare and count
	task automatic check(input string nm, input logic [7:0] sn, input logic [7:0] ex);
		total_checks++;
		if (sn !== ex) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one-cycle register write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clock);
		wr_stb <= 1'b0;
	endtask
	// one-cycle read, data taken in the following cycle
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clock);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clock);
		#1;
	endtask
	// count reset-in pulses while pins move to a new pattern
	task automatic move_pins(input logic [7:0] v, output int pulses);
		@(posedge clock);
		ext_val <= v;
		pulses = 0;
		repeat (8) begin
			@(posedge clock);
			#1 pulses += int'(cc_rst);
		end
	endtask
	// hang guard
	initial begin
		#10000;
		miscompares++;
		report_and_stop();
	end
	// main sequence
	initial begin
		settle(6);
		check("oe in reset", pin_oe, 8'h00);
		check("pull in reset", pin_pu, 8'hFF);
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		for (int a = 0; a < 8; a++) begin
			rd(3'(a), q);
			check("reset value", q, (a == 0 || a == 3) ? 8'hFF : 8'h00);
		end
		wr(PST, 8'h00);
		wr(IST, 8'hFF);
		rd(PST, q);
		check("pin state ro", q, 8'hFF);
		rd(IST, q);
		check("status ro", q, 8'h00);
		// mode table
		foreach (rows[i]) begin
			wr(MLO, rows[i].lo);
			wr(MHI, rows[i].hi);
			wr(LAT, rows[i].d);
			settle(2);
			check("oe", pin_oe, rows[i].oe);
			check("out", pin_out & pin_oe, rows[i].out);
			check("pullup", pin_pu, rows[i].pu);
			rd(MLO, q);
			check("mode low", q, rows[i].lo);
		end
		// alternate outputs in push-pull, then open drain
		wr(MLO, 8'h00);
		wr(MHI, 8'hFF);
		wr(LAT, 8'hFF);
		@(posedge clock);
		{txd_en, cmp_en, xacc, txd, cmp, xwr_n, xrd_n} <= {6'h3F, 1'b0, 4'hA, 2'b01};
		settle(3);
		check("alt out a", pin_out, 8'hA9);
		@(posedge clock);
		{txd, cmp, xwr_n, xrd_n} <= {1'b1, 4'h5, 2'b10};
		settle(3);
		check("alt out b", pin_out, 8'h57);
		wr(LAT, 8'h00);
		settle(2);
		check("alt gated", pin_out, 8'h00);
		wr(LAT, 8'hFF);
		wr(MLO, 8'hFF);
		{txd, cmp, xwr_n, xrd_n} <= {1'b0, 4'hA, 2'b01};
		settle(3);
		check("alt drain", pin_oe, 8'h56);
		// alternate inputs through high-impedance pins
		wr(MHI, 8'h00);
		ext_en <= 8'hFF;
		move_pins(8'h35, n);
		wr(ICL, 8'h0F);
		move_pins(8'hCA, n);
		check("rise pulses", 8'(n), 8'h01);
		check("alt in", {2'b00, cnt1, cnt0, irq1, irq0, cc_ev, rxd}, 8'h08);
		rd(PST, q);
		check("pin state", q, 8'hCA);
		rd(IST, q);
		check("events", q, 8'h03);
		check("irq masked", {7'h00, irq}, 8'h00);
		wr(IEN, 8'h02);
		settle(1);
		check("irq on", {7'h00, irq}, 8'h01);
		wr(ICL, 8'h02);
		rd(IST, q);
		check("cleared", q, 8'h01);
		check("irq off", {7'h00, irq}, 8'h00);
		wr(ICL, 8'h01);
		move_pins(8'h35, n);
		check("fall pulses", 8'(n), 8'h00);
		check("alt in b", {2'b00, cnt1, cnt0, irq1, irq0, cc_ev, rxd}, 8'h37);
		rd(IST, q);
		check("fall event", q, 8'h04);
		// watchdog pulse on the reset pin
		// overflow lands in the same cycle as a clear of its status bit
		@(posedge clock);
		{addr, wdata, wr_stb, wdt_ovf} <= {ICL, 8'h08, 2'b11};
		@(posedge clock);
		{wr_stb, wdt_ovf} <= 2'b00;
		n = 0;
		seen = 1'b0;
		repeat (40) begin
			#1 n += int'(rst_oe);
			seen |= dev_rst;
			@(posedge clock);
		end
		check("pulse len", 8'(n), 8'(PULSE_CYC));
		check("pulse resets", {7'h00, seen}, 8'h01);
		rd(IST, q);
		check("wdt event", q, 8'h0C);
		@(posedge clock);
		rst_btn_n <= 1'b0;
		settle(6);
		check("button", {7'h00, dev_rst}, 8'h01);
		@(posedge clock);
		rst_btn_n <= 1'b1;
		settle(6);
		check("button off", {7'h00, dev_rst}, 8'h00);
		// reset mid-run forces weak high before any clock edge
		ext_en <= 8'h00;
		wr(MLO, 8'h00);
		wr(MHI, 8'hFF);
		wr(LAT, 8'h00);
		@(posedge clock);
		reset <= 1'b1;
		#1 check("async oe", pin_oe, 8'h00);
		check("async pull", pin_pu, 8'hFF);
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		rd(MHI, q);
		check("mode default", q, 8'h00);
		report_and_stop();
	end
endmodule
